// >>> pkg/lpmc_pkg.sv
package lpmc_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;  // power_ctrl_reg_a
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;  // power_ctrl_reg_b
  localparam logic [7:0] ADDR_KEY_WAKE = 8'h08;  // key_wake_enable_reg
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;  // Block state
  localparam logic [7:0] ADDR_CPU_IF   = 8'h10;  // Program counter readback (read only)

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int A_STOP_BIT  = 7;
  localparam int A_RELEASE_SENSE_SELECT_BIT  = 6;
  localparam int A_RETURN_MODE_SELECT_BIT  = 5;
  localparam int A_HOLD_BIT  = 4;
  localparam int A_WUT_LSB   = 1;
  localparam int B_XEN_BIT   = 7;
  localparam int B_XTEN_BIT  = 6;
  localparam int B_SYSCK_BIT = 5;
  localparam int B_HALT_BIT  = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h80;
  localparam logic [3:0] KEY_RST    = 4'h0;

  // ****************************************************************
  // Warm-up exponents
  // ****************************************************************
  localparam int WU_FAST_E16 = 16;
  localparam int WU_FAST_E14 = 14;
  localparam int WU_FAST_E10 = 10;
  localparam int WU_SLOW_E13 = 13;
  localparam int WU_SLOW_E6  = 6;
  localparam int WU_CNT_W    = 18;

  // Run modes
  typedef enum logic [1:0] {
    LPMC_RUN_FAST1 = 2'b00,
    LPMC_RUN_FAST2 = 2'b01,
    LPMC_RUN_SLOW  = 2'b10
  } lpmc_run_t;

  // Controller states
  typedef enum logic [1:0] {
    LPMC_ST_RUN    = 2'b00,
    LPMC_ST_STOP   = 2'b01,
    LPMC_ST_WARMUP = 2'b10,
    LPMC_ST_HALT   = 2'b11
  } lpmc_state_t;

endpackage : lpmc_pkg

// >>> verilog/lpmc_ctrl.sv
// Contract
// RULE_01: Writing stop bit one enters deep stop
// RULE_02: Stop kills oscillators, halts, state held
// RULE_03: Stop entry clears prescaler and divider
// RULE_04: PC left two past mode-start instruction
// RULE_05: Level mode: release pin or key wake
// RULE_06: Active release at stop write starts warm-up
// RULE_07: Software checks release idle before stopping
// RULE_08: No re-entry to stop during warm-up
// RULE_09: Edge-to-level switch waits for rising edge
// RULE_10: Edge mode: rising edge only, stop anyway
// RULE_11: Software avoids key wake in edge mode
// RULE_12: Restart oscillators according to return mode
// RULE_13: Warm-up halted, length from three-bit select
// RULE_14: After warm-up resume next instruction
// RULE_15: Reset pin releases all, fast single run
// RULE_16: Software masks interrupts around stop
// RULE_17: Halt stops CPU and watchdog only
// RULE_18: Software order: MASTER_IRQ_ENABLE off, EF on, halt
// RULE_19: Halt exit self-clears bit, prior run mode
// RULE_20: MASTER_IRQ_ENABLE zero: enabled irq resumes, no service
// RULE_21: MASTER_IRQ_ENABLE one: enabled irq starts service
// RULE_22: Watchdog irq just before halt cancels halt
// RULE_23: Return select picks fast or slow run
// RULE_24: Warm-up counts per code and clock
// RULE_25: Hold enable keeps ports driven in stop
// RULE_26: Warm-up counter gates CPU clock until done
//
// Design decisions made here: register access over APB and the register addresses.
module lpmc_ctrl #(
  parameter int NUM_KEYS = 4 // Key wake-up inputs
) (
  input  wire logic                pclk,              // APB clock
  input  wire logic                presetn,           // Reset pin, active low
  input  wire logic                psel,              // APB select
  input  wire logic                penable,           // APB enable
  input  wire logic                pwrite,            // APB direction
  input  wire logic [7:0]          paddr,             // APB address
  input  wire logic [31:0]         pwdata,            // APB write data
  output logic      [31:0]         prdata,            // APB read data
  output logic                     pready,            // APB ready
  output logic                     pslverr,           // APB error
  input  wire logic                release_pin,       // Stop release pin level
  input  wire logic [NUM_KEYS-1:0] key_wakeup_inputs, // Active low keys
  input  wire logic                irq_pending,       // Latched and enabled irq
  input  wire logic                master_irq_enable, // CPU master enable
  input  wire logic                wdt_irq,           // Watchdog interrupt
  input  wire logic                pc_advance,        // CPU retires instruction
  output logic                     cpu_clk_en,        // CPU clock gate
  output logic                     wdt_run,           // Watchdog runs
  output logic                     periph_clk_en,     // Peripheral clock
  output logic                     fast_osc_en,       // Fast oscillator
  output logic                     slow_osc_en,       // Slow oscillator
  output logic                     divider_clr,       // Clear prescaler chain
  output logic                     port_out_en,       // Port drivers enabled
  output logic                     release_pin_oe,    // Release pin driver
  output logic                     irq_service,       // Take interrupt vector
  output logic      [15:0]         pc_out             // Program counter
);

  initial
  begin
    if (NUM_KEYS < 1 || NUM_KEYS > 8)
      $error("NUM_KEYS out of range");
  end

  // ****************************************************************
  // Warm-up terminal count
  // ****************************************************************
  function automatic logic [lpmc_pkg::WU_CNT_W-1:0] wu_count(input logic [2:0] sel,
                                                             input logic       slow);
    logic [lpmc_pkg::WU_CNT_W-1:0] one;
    logic [lpmc_pkg::WU_CNT_W-1:0] b;
    one = {{(lpmc_pkg::WU_CNT_W-1){1'b0}}, 1'b1};
    if (sel[0])
      b = one << (slow ? lpmc_pkg::WU_SLOW_E6 : lpmc_pkg::WU_FAST_E10);
    else if (sel[2])
      b = one << (slow ? lpmc_pkg::WU_SLOW_E6 : lpmc_pkg::WU_FAST_E14);
    else
      b = one << (slow ? lpmc_pkg::WU_SLOW_E13 : lpmc_pkg::WU_FAST_E16);
    wu_count = sel[1] ? b : (b + (b << 1));
  endfunction

  lpmc_pkg::lpmc_state_t         state_reg, state_next;
  lpmc_pkg::lpmc_run_t           run_reg, run_next;
  logic [7:0]                    a_reg, a_next;
  logic [7:0]                    b_reg, b_next;
  logic [NUM_KEYS-1:0]           key_reg, key_next;
  logic                          edge_mode_reg, edge_mode_next;
  logic                          pin_q_reg, pin_q_next;
  logic [lpmc_pkg::WU_CNT_W-1:0] wu_reg, wu_next;
  logic [lpmc_pkg::WU_CNT_W-1:0] wu_term_reg, wu_term_next;
  logic [15:0]                   pc_reg, pc_next;
  logic                          svc_reg, svc_next;
  logic [31:0]                   rdata_reg, rdata_next;

  logic wr, rd, rise, key_hit, level_rel, release_now, mapped;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign rise    = release_pin && !pin_q_reg;
  assign key_hit = |(key_reg & ~key_wakeup_inputs[NUM_KEYS-1:0]);
  assign level_rel = release_pin || key_hit;                              // RULE_05
  assign release_now = edge_mode_reg ? rise : level_rel;                  // RULE_10
  assign mapped  = paddr == lpmc_pkg::ADDR_CTRL_A || paddr == lpmc_pkg::ADDR_CTRL_B
                || paddr == lpmc_pkg::ADDR_KEY_WAKE || paddr == lpmc_pkg::ADDR_STATUS
                || paddr == lpmc_pkg::ADDR_CPU_IF;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    state_next     = state_reg;
    run_next       = run_reg;
    a_next         = a_reg;
    b_next         = b_reg;
    key_next       = key_reg;
    pin_q_next     = release_pin;
    wu_next        = wu_reg;
    wu_term_next   = wu_term_reg;
    pc_next        = pc_reg;
    svc_next       = 1'b0;
    rdata_next     = rdata_reg;
    edge_mode_next = edge_mode_reg;
    // Level mode only takes effect after a rising edge
    if (!a_reg[lpmc_pkg::A_RELEASE_SENSE_SELECT_BIT])
      edge_mode_next = 1'b1;
    else if (rise)
      edge_mode_next = 1'b0;                                              // RULE_09
    if (wr)
    begin
      unique case (paddr)
        lpmc_pkg::ADDR_CTRL_A:   a_next = pwdata[7:0];
        lpmc_pkg::ADDR_CTRL_B:   b_next = pwdata[7:0];
        lpmc_pkg::ADDR_KEY_WAKE: key_next = pwdata[NUM_KEYS-1:0];
        default:                 a_next = a_next;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        lpmc_pkg::ADDR_CTRL_A:   rdata_next = {24'h0, a_reg};
        lpmc_pkg::ADDR_CTRL_B:   rdata_next = {24'h0, b_reg};
        lpmc_pkg::ADDR_KEY_WAKE: rdata_next = {{(32-NUM_KEYS){1'b0}}, key_reg};
        lpmc_pkg::ADDR_STATUS:   rdata_next = {26'h0, edge_mode_reg, release_pin,
                                               run_reg, state_reg};
        lpmc_pkg::ADDR_CPU_IF:   rdata_next = {16'h0, pc_reg};
        default:                 rdata_next = 32'h0;
      endcase
    end
    unique case (state_reg)
      lpmc_pkg::LPMC_ST_RUN:
      begin
        if (pc_advance)
          pc_next = pc_reg + 16'h0001;
        if (a_next[lpmc_pkg::A_STOP_BIT] && !a_reg[lpmc_pkg::A_STOP_BIT])
        begin
          pc_next = pc_reg + 16'h0002;                                    // RULE_04
          run_next = a_next[lpmc_pkg::A_RETURN_MODE_SELECT_BIT] ? lpmc_pkg::LPMC_RUN_SLOW
                   : (b_reg[lpmc_pkg::B_XTEN_BIT] ? lpmc_pkg::LPMC_RUN_FAST2
                                                  : lpmc_pkg::LPMC_RUN_FAST1); // RULE_23
          wu_term_next = wu_count(a_next[lpmc_pkg::A_WUT_LSB+2:lpmc_pkg::A_WUT_LSB],
                                  a_next[lpmc_pkg::A_RETURN_MODE_SELECT_BIT]);          // RULE_24
          wu_next = '0;
          if (!edge_mode_reg && level_rel)
            state_next = lpmc_pkg::LPMC_ST_WARMUP;                        // RULE_06
          else
            state_next = lpmc_pkg::LPMC_ST_STOP;                          // RULE_01
        end
        else if (b_next[lpmc_pkg::B_HALT_BIT] && !b_reg[lpmc_pkg::B_HALT_BIT])
        begin
          if (wdt_irq)
          begin
            b_next[lpmc_pkg::B_HALT_BIT] = 1'b0;                          // RULE_22
            svc_next = 1'b1;
          end
          else
          begin
            pc_next = pc_reg + 16'h0002;                                  // RULE_04
            state_next = lpmc_pkg::LPMC_ST_HALT;
          end
        end
      end
      lpmc_pkg::LPMC_ST_STOP:
      begin
        wu_next = '0;
        if (release_now)
          state_next = lpmc_pkg::LPMC_ST_WARMUP;                          // RULE_05
      end
      lpmc_pkg::LPMC_ST_WARMUP:
      begin
        wu_next = wu_reg + 1'b1;                                          // RULE_26
        if (wu_next >= wu_term_reg)
        begin
          state_next = lpmc_pkg::LPMC_ST_RUN;                             // RULE_14
          a_next[lpmc_pkg::A_STOP_BIT] = 1'b0;
          b_next[lpmc_pkg::B_SYSCK_BIT] = run_reg == lpmc_pkg::LPMC_RUN_SLOW;
          b_next[lpmc_pkg::B_XEN_BIT]  = run_reg != lpmc_pkg::LPMC_RUN_SLOW;
        end
      end
      lpmc_pkg::LPMC_ST_HALT:
      begin
        if (irq_pending)
        begin
          state_next = lpmc_pkg::LPMC_ST_RUN;
          b_next[lpmc_pkg::B_HALT_BIT] = 1'b0;                            // RULE_19
          svc_next = master_irq_enable;                                   // RULE_20 RULE_21
        end
      end
      default: state_next = lpmc_pkg::LPMC_ST_RUN;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= lpmc_pkg::LPMC_ST_RUN;                             // RULE_15
      run_reg       <= lpmc_pkg::LPMC_RUN_FAST1;
      a_reg         <= lpmc_pkg::CTRL_A_RST;
      b_reg         <= lpmc_pkg::CTRL_B_RST;
      key_reg       <= lpmc_pkg::KEY_RST;
      edge_mode_reg <= 1'b1;
      pin_q_reg     <= 1'b0;
      wu_reg        <= '0;
      wu_term_reg   <= '0;
      pc_reg        <= 16'h0000;
      svc_reg       <= 1'b0;
      rdata_reg     <= 32'h0;
    end
    else
    begin
      state_reg     <= state_next;
      run_reg       <= run_next;
      a_reg         <= a_next;
      b_reg         <= b_next;
      key_reg       <= key_next;
      edge_mode_reg <= edge_mode_next;
      pin_q_reg     <= pin_q_next;
      wu_reg        <= wu_next;
      wu_term_reg   <= wu_term_next;
      pc_reg        <= pc_next;
      svc_reg       <= svc_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic in_stop;
  assign in_stop        = state_reg == lpmc_pkg::LPMC_ST_STOP;
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !mapped;
  assign prdata         = rdata_reg;
  assign cpu_clk_en     = state_reg == lpmc_pkg::LPMC_ST_RUN;             // RULE_17
  assign wdt_run        = state_reg == lpmc_pkg::LPMC_ST_RUN;
  assign periph_clk_en  = !in_stop && state_reg != lpmc_pkg::LPMC_ST_WARMUP; // RULE_13
  assign fast_osc_en    = !in_stop && run_reg != lpmc_pkg::LPMC_RUN_SLOW;  // RULE_02 RULE_12
  assign slow_osc_en    = !in_stop && (run_reg != lpmc_pkg::LPMC_RUN_FAST1);
  assign divider_clr    = in_stop;                                        // RULE_03
  assign port_out_en    = !in_stop || a_reg[lpmc_pkg::A_HOLD_BIT];        // RULE_25
  assign release_pin_oe = !in_stop;
  assign irq_service    = svc_reg;
  assign pc_out         = pc_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_no_restop;
    @(posedge pclk) disable iff (!presetn)
    state_reg == lpmc_pkg::LPMC_ST_WARMUP |=> state_reg != lpmc_pkg::LPMC_ST_STOP;
  endproperty
  a_no_restop: assert property (p_no_restop) else $error("Stop re-entered"); // RULE_08

  property p_halt_clear;
    @(posedge pclk) disable iff (!presetn)
    state_reg == lpmc_pkg::LPMC_ST_HALT && irq_pending
      |=> !b_reg[lpmc_pkg::B_HALT_BIT] && state_reg == lpmc_pkg::LPMC_ST_RUN;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("Halt bit kept"); // RULE_19

  property p_stop_quiet;
    @(posedge pclk) disable iff (!presetn)
    in_stop |-> !fast_osc_en && !slow_osc_en && !cpu_clk_en && divider_clr;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("Stop not quiet"); // RULE_02

  property p_edge_only;
    @(posedge pclk) disable iff (!presetn)
    in_stop && edge_mode_reg && !rise |=> in_stop;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("Edge release wrong"); // RULE_10

  property p_svc;
    @(posedge pclk) disable iff (!presetn)
    state_reg == lpmc_pkg::LPMC_ST_HALT && irq_pending |=> irq_service == $past(master_irq_enable);
  endproperty
  a_svc: assert property (p_svc) else $error("Service choice wrong"); // RULE_21

  property p_wdt;
    @(posedge pclk) disable iff (!presetn)
    state_reg == lpmc_pkg::LPMC_ST_RUN && wdt_irq && !(a_next[lpmc_pkg::A_STOP_BIT]
      && !a_reg[lpmc_pkg::A_STOP_BIT]) |=> state_reg != lpmc_pkg::LPMC_ST_HALT;
  endproperty
  a_wdt: assert property (p_wdt) else $error("Halt despite watchdog"); // RULE_22

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    state_reg == lpmc_pkg::LPMC_ST_WARMUP |-> !cpu_clk_en && !periph_clk_en;
  endproperty
  a_gate: assert property (p_gate) else $error("Clock ungated in warm-up"); // RULE_26

  property p_ports;
    @(posedge pclk) disable iff (!presetn)
    in_stop |-> port_out_en == a_reg[lpmc_pkg::A_HOLD_BIT] && !release_pin_oe;
  endproperty
  a_ports: assert property (p_ports) else $error("Port drive wrong"); // RULE_25

endmodule // lpmc_ctrl

// >>> test/lpmc_wake_src.sv
// ****************************************************************
// Wake sources: registered release pin and active-low key inputs
// ****************************************************************
module lpmc_wake_src (
  input  wire logic       pclk,              // Clock
  input  wire logic       pin_req,           // Raise release pin
  input  wire logic [3:0] key_req,           // Press keys
  output logic            release_pin,       // Release pin level
  output logic      [3:0] key_wakeup_inputs  // Keys, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk)
  begin
    release_pin       <= pin_req;
    key_wakeup_inputs <= ~key_req;
  end
endmodule // lpmc_wake_src

// >>> test/lpmc_ctrl_tb.sv
module lpmc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pin_req, irq_pending, mie, wdt_irq, pc_adv;
  logic        pready, pslverr, err, release_pin, cpu_clk_en, wdt_run, periph_clk_en, fo, so;
  logic        fast_osc_en, slow_osc_en, divider_clr, port_out_en, release_pin_oe, irq_service;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  key_req, key_in;
  logic [15:0] pc_out, exp_pc;
  int          bad_count, total_checks, svc, s0, wu, stc, n;
  logic [7:0]  rows_a [6] = '{8'h86, 8'hb6, 8'h82, 8'ha2, 8'h8c, 8'ha0};
  logic [7:0]  rows_b [6] = '{8'hc0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};

  lpmc_wake_src i_src (.pclk(pclk), .pin_req(pin_req), .key_req(key_req),
                       .release_pin(release_pin), .key_wakeup_inputs(key_in));
  lpmc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .release_pin(release_pin), .key_wakeup_inputs(key_in),
    .irq_pending(irq_pending), .master_irq_enable(mie), .wdt_irq(wdt_irq),
    .pc_advance(pc_adv), .cpu_clk_en(cpu_clk_en), .wdt_run(wdt_run),
    .periph_clk_en(periph_clk_en), .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
    .divider_clr(divider_clr), .port_out_en(port_out_en), .release_pin_oe(release_pin_oe),
    .irq_service(irq_service), .pc_out(pc_out));

  // ****************************************************************
  // Helpers and reference model
  // ****************************************************************
  function automatic int wu_len(input logic [7:0] a);
    int f [8] = '{3 << 16, 3 << 10, 1 << 16, 1 << 10, 3 << 14, 3 << 10, 1 << 14, 1 << 10};
    int s [8] = '{3 << 13, 3 << 6, 1 << 13, 1 << 6, 3 << 6, 3 << 6, 1 << 6, 1 << 6};
    return a[5] ? s[a[3:1]] : f[a[3:1]];
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic settle();
    @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wait_run();
    wu = 0;
    stc = 0;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
      if (cpu_clk_en !== 1'h1 && (fast_osc_en === 1'h1 || slow_osc_en === 1'h1))
      begin
        wu++;
        if (wu == 1)
        begin
          fo = fast_osc_en;
          so = slow_osc_en;
        end
      end
      else if (cpu_clk_en !== 1'h1)
        stc++;
    end
    while (cpu_clk_en !== 1'h1 && n < 30000);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  always @(negedge pclk)
    if (irq_service === 1'h1)
      svc++;

  initial
  begin
    #(100000 * 40);
    bad_count++;
    give_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, pin_req, irq_pending, mie, wdt_irq, pc_adv} = '0;
    {paddr, pwdata, key_req} = '0;
    {bad_count, total_checks, svc} = '0;
    exp_pc = 16'h0;
    void'($urandom(40170));
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, lpmc_pkg::ADDR_CTRL_A, 32'h0);
    chk("ctrl_a", rd, {24'h0, lpmc_pkg::CTRL_A_RST});
    apb(1'h0, lpmc_pkg::ADDR_CTRL_B, 32'h0);
    chk("ctrl_b", rd, {24'h0, lpmc_pkg::CTRL_B_RST});
    apb(1'h0, lpmc_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h20);
    apb(1'h1, 8'h20, 32'hff);
    chk("wr_err", err, 32'h1);
    apb(1'h0, 8'h14, 32'h0);
    chk("rd_err", {rd[30:0], err}, 32'h1);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, lpmc_pkg::ADDR_CTRL_B, {24'h0, rows_b[i]});
      n = $urandom_range(1, 8);
      repeat (n)
      begin
        @(posedge pclk);
        pc_adv <= 1'h1;
      end
      @(posedge pclk);
      pc_adv <= 1'h0;
      pin_req <= 1'h1;
      exp_pc = exp_pc + n[15:0] + 16'h2;
      apb(1'h1, lpmc_pkg::ADDR_CTRL_A, {24'h0, rows_a[i]});
      settle();
      chk("cpu_stop", cpu_clk_en, 32'h0);
      chk("osc_stop", {fast_osc_en, slow_osc_en}, 32'h0);
      chk("div_clr", divider_clr, 32'h1);
      chk("port_en", port_out_en, rows_a[i][4]);
      chk("pin_oe", release_pin_oe, 32'h0);
      chk("pc_stop", pc_out, exp_pc);
      @(posedge pclk);
      pin_req <= 1'h0;
      settle();
      @(posedge pclk);
      pin_req <= 1'h1;
      wait_run();
      chk("wu_len", wu, wu_len(rows_a[i]));
      chk("osc", {fo, so}, {!rows_a[i][5], rows_a[i][5] | rows_b[i][6]});
      chk("pc_run", pc_out, exp_pc);
      apb(1'h0, lpmc_pkg::ADDR_CTRL_A, 32'h0);
      chk("stop_clr", rd, rows_a[i] & 8'h7f);
    end
    $display("test stop rows done");
    for (int m = 0; m < 2; m++)
    begin
      mie <= m[0];
      apb(1'h1, lpmc_pkg::ADDR_CTRL_B, 32'h90);
      exp_pc = exp_pc + 16'h2;
      settle();
      chk("halt", {cpu_clk_en, wdt_run, periph_clk_en}, 32'h1);
      chk("pc_halt", pc_out, exp_pc);
      s0 = svc;
      @(posedge pclk);
      irq_pending <= 1'h1;
      settle();
      settle();
      chk("halt_end", cpu_clk_en, 32'h1);
      chk("service", svc - s0, m);
      @(posedge pclk);
      irq_pending <= 1'h0;
      apb(1'h0, lpmc_pkg::ADDR_CTRL_B, 32'h0);
      chk("halt_clr", rd, 32'h80);
    end
    wdt_irq <= 1'h1;
    s0 = svc;
    apb(1'h1, lpmc_pkg::ADDR_CTRL_B, 32'h90);
    wdt_irq <= 1'h0;
    settle();
    settle();
    chk("wdt_run", cpu_clk_en, 32'h1);
    chk("wdt_svc", svc - s0, 32'h1);
    $display("test halt done");
    apb(1'h1, lpmc_pkg::ADDR_CTRL_A, 32'h86);
    @(posedge pclk);
    presetn <= 1'h0;
    settle();
    @(posedge pclk);
    presetn <= 1'h1;
    settle();
    chk("rst_rel", {cpu_clk_en, fast_osc_en, slow_osc_en, pc_out}, {3'h6, 16'h0});
    apb(1'h1, lpmc_pkg::ADDR_CTRL_A, 32'h40);
    apb(1'h1, lpmc_pkg::ADDR_CTRL_A, 32'hc6);
    settle();
    chk("edge_kept", divider_clr, 32'h1);
    @(posedge pclk);
    pin_req <= 1'h0;
    settle();
    @(posedge pclk);
    pin_req <= 1'h1;
    wait_run();
    apb(1'h0, lpmc_pkg::ADDR_STATUS, 32'h0);
    chk("level_on", rd[5], 32'h0);
    apb(1'h1, lpmc_pkg::ADDR_CTRL_A, 32'hc6);
    settle();
    chk("no_stop", {cpu_clk_en, fast_osc_en, divider_clr}, 32'h2);
    @(posedge pclk);
    pin_req <= 1'h0;
    wait_run();
    chk("no_reentry", stc, 32'h0);
    apb(1'h1, lpmc_pkg::ADDR_KEY_WAKE, 32'h1);
    apb(1'h1, lpmc_pkg::ADDR_CTRL_A, 32'hc6);
    key_req <= 4'h2;
    repeat (4) settle();
    chk("key_off", divider_clr, 32'h1);
    @(posedge pclk);
    key_req <= 4'h1;
    wait_run();
    chk("key_wake", wu, wu_len(8'hc6));
    $display("test level release done");
    give_verdict();
  end
endmodule // lpmc_ctrl_tb
